// [src/ced_comparator.sv]
// Comparator edge control: registers, output paths, edge flags, interrupt
`include "ced_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module ced_comparator (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Analog core
  input  wire logic                     cmp_result_in,
  output wire ced_pkg::ced_analog_cfg_t analog_cfg,
  // Control register access
  input  wire logic                     ctrl_wr_en,
  input  wire logic [7:0]               ctrl_wr_data,
  output logic      [7:0]               comparator_control_register,
  // Input select register access
  input  wire logic                     mux_wr_en,
  input  wire logic [7:0]               mux_wr_data,
  output logic      [7:0]               comparator_input_select_register,
  // Mode register access
  input  wire logic                     mode_wr_en,
  input  wire logic [7:0]               mode_wr_data,
  output logic      [7:0]               comparator_mode_register,
  // Outputs to pins, interrupt and reset logic
  output logic                          raw_compare_output,
  output logic                          latched_compare_output,
  output logic                          irq_request,
  output logic                          reset_source
);

  // ========================================================================
  // Register state
  ced_pkg::ced_ctrl_t ctrl_q;
  ced_pkg::ced_ctrl_t ctrl_d;
  ced_pkg::ced_mux_t  mux_q;
  ced_pkg::ced_mux_t  mux_d;
  ced_pkg::ced_mode_t mode_q;
  ced_pkg::ced_mode_t mode_d;

  // ========================================================================
  // Output path state
  logic sync_q;
  logic sync_d;
  logic latched_q;
  logic latched_d;
  logic prev_q;
  logic prev_d;
  logic rise_evt;
  logic fall_evt;

  // ========================================================================
  // Raw path: a gate only, so it keeps following the core while the
  // clock is stopped; the enable flop simply holds its value then
  assign raw_compare_output = cmp_result_in & ctrl_q.enable;

  // ========================================================================
  // Synchroniser and edge detection
  always_comb begin
    sync_d    = cmp_result_in;
    latched_d = ctrl_q.enable ? sync_q : 1'b0;
    prev_d    = latched_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_q    <= 1'b0;
      latched_q <= 1'b0;
      prev_q    <= 1'b0;
    end else begin
      sync_q    <= sync_d;
      latched_q <= latched_d;
      prev_q    <= prev_d;
    end
  end

  // Only while enabled, so switching off does not fake a falling edge;
  // switching on may still flag a spurious edge, as the core settles
  assign rise_evt = ctrl_q.enable & latched_q & ~prev_q;
  assign fall_evt = ctrl_q.enable & ~latched_q & prev_q;

  // ========================================================================
  // Registers
  always_comb begin
    ctrl_d = ctrl_q;
    mux_d  = mux_q;
    mode_d = mode_q;
    if (ctrl_wr_en) begin
      ctrl_d.enable = ctrl_wr_data[`CED_CTRL_EN_BIT];
      ctrl_d.positive_hysteresis_select =
        ced_pkg::ced_hyst_t'(ctrl_wr_data[`CED_CTRL_HYP_LSB +: 2]);
      ctrl_d.negative_hysteresis_select =
        ced_pkg::ced_hyst_t'(ctrl_wr_data[`CED_CTRL_HYN_LSB +: 2]);
      // Writing zero clears a flag; writing one leaves it as it is
      if (!ctrl_wr_data[`CED_CTRL_RISE_BIT]) begin
        ctrl_d.rising_edge_flag = 1'b0;
      end
      if (!ctrl_wr_data[`CED_CTRL_FALL_BIT]) begin
        ctrl_d.falling_edge_flag = 1'b0;
      end
    end
    // Set after clear so a coincident edge is never lost
    if (rise_evt) begin
      ctrl_d.rising_edge_flag = 1'b1;
    end
    if (fall_evt) begin
      ctrl_d.falling_edge_flag = 1'b1;
    end
    ctrl_d.out_status = 1'b0;
    if (mux_wr_en) begin
      mux_d = ced_pkg::ced_mux_t'(mux_wr_data);
    end
    if (mode_wr_en) begin
      mode_d = ced_pkg::ced_mode_t'(mode_wr_data & `CED_MODE_WR_MASK);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= ced_pkg::ced_ctrl_t'(`CED_CTRL_RST);
      mux_q  <= ced_pkg::ced_mux_t'(`CED_MUX_RST);
      mode_q <= ced_pkg::ced_mode_t'(`CED_MODE_RST);
    end else begin
      ctrl_q <= ctrl_d;
      mux_q  <= mux_d;
      mode_q <= mode_d;
    end
  end

  // ========================================================================
  // Read images; status bit is live, never stored
  always_comb begin
    comparator_control_register = ctrl_q;
    comparator_control_register[`CED_CTRL_OUT_BIT] = latched_q;
    comparator_input_select_register = mux_q;
    comparator_mode_register = mode_q;
  end

  // ========================================================================
  // Pin decode towards the analog multiplexers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign analog_cfg.pos_pin_sel[gi] =
        ~mux_q.positive_input_select[`CED_MUX_NONE_BIT] &
        (mux_q.positive_input_select[2:0] == 3'(gi));
      assign analog_cfg.neg_pin_sel[gi] =
        ~mux_q.negative_input_select[`CED_MUX_NONE_BIT] &
        (mux_q.negative_input_select[2:0] == 3'(gi));
    end
  endgenerate

  assign analog_cfg.enable   = ctrl_q.enable;
  assign analog_cfg.pos_hyst = ctrl_q.positive_hysteresis_select;
  assign analog_cfg.neg_hyst = ctrl_q.negative_hysteresis_select;
  assign analog_cfg.resp     = mode_q.response_time_select;

  // ========================================================================
  // Result fan-out
  assign latched_compare_output = latched_q;
  assign irq_request =
    (ctrl_q.rising_edge_flag & mode_q.rising_edge_irq_enable) |
    (ctrl_q.falling_edge_flag & mode_q.falling_edge_irq_enable);
  // Level from the clocked path; the reset controller decides polarity use
  assign reset_source = latched_q;

endmodule

`default_nettype wire

// [src/ced_consts.svh]
// Field positions, reset values and masks of the comparator edge control block
`ifndef CED_CONSTS_SVH
`define CED_CONSTS_SVH

// ==========================================================================
// Control register fields
`define CED_CTRL_EN_BIT      3'd7
`define CED_CTRL_OUT_BIT     3'd6
`define CED_CTRL_RISE_BIT    3'd5
`define CED_CTRL_FALL_BIT    3'd4
`define CED_CTRL_HYP_LSB     3'd2
`define CED_CTRL_HYN_LSB     3'd0
`define CED_CTRL_RST         8'h00

// ==========================================================================
// Input select register fields
`define CED_MUX_NEG_LSB      3'd4
`define CED_MUX_POS_LSB      3'd0
`define CED_MUX_NONE_BIT     2'd3
`define CED_MUX_RST          8'hFF

// ==========================================================================
// Mode register fields
`define CED_MODE_RIE_BIT     3'd5
`define CED_MODE_FIE_BIT     3'd4
`define CED_MODE_MD_LSB      3'd0
`define CED_MODE_WR_MASK     8'h33
`define CED_MODE_RST         8'h02

`endif

// [src/ced_pkg.sv]
// Types of the comparator edge control block
package ced_pkg;

  // ========================================================================
  // Response time modes, fastest first
  typedef enum logic [1:0] {
    CED_RESP_MODE0 = 2'h0,
    CED_RESP_MODE1 = 2'h1,
    CED_RESP_MODE2 = 2'h2,
    CED_RESP_MODE3 = 2'h3
  } ced_resp_t;

  // ========================================================================
  // Hysteresis amounts
  typedef enum logic [1:0] {
    CED_HYST_OFF  = 2'h0,
    CED_HYST_5MV  = 2'h1,
    CED_HYST_10MV = 2'h2,
    CED_HYST_20MV = 2'h3
  } ced_hyst_t;

  // ========================================================================
  // Register images
  typedef struct packed {
    logic      enable;
    logic      out_status;
    logic      rising_edge_flag;
    logic      falling_edge_flag;
    ced_hyst_t positive_hysteresis_select;
    ced_hyst_t negative_hysteresis_select;
  } ced_ctrl_t;

  typedef struct packed {
    logic [3:0] negative_input_select;
    logic [3:0] positive_input_select;
  } ced_mux_t;

  typedef struct packed {
    logic [1:0] unused_hi;
    logic       rising_edge_irq_enable;
    logic       falling_edge_irq_enable;
    logic [1:0] unused_lo;
    ced_resp_t  response_time_select;
  } ced_mode_t;

  // ========================================================================
  // Settings handed to the analog core
  typedef struct packed {
    logic       enable;
    logic [7:0] pos_pin_sel;
    logic [7:0] neg_pin_sel;
    ced_hyst_t  pos_hyst;
    ced_hyst_t  neg_hyst;
    ced_resp_t  resp;
  } ced_analog_cfg_t;

endpackage

// [verif/ced_analog_model.sv]
// Behavioural analog comparator core with a mode dependent response delay
`timescale 1ns/10ps
`default_nettype none
// ====================
// Core model
module ced_analog_model (
  // System clock and settings
  input  wire logic                     clock,
  input  wire ced_pkg::ced_analog_cfg_t analog_cfg,
  // Sign of the pin voltage difference
  input  wire logic                     diff_pos,
  // Decision towards the block
  output var  logic                     cmp_result_in
);
  logic [7:0] hist = 8'h00;
  initial cmp_result_in = 1'b0;
  // Slower modes answer later; a core that is off gives no settled level, so it toggles
  always @(posedge clock) begin
    hist <= {hist[6:0], diff_pos};
    #3 cmp_result_in <= analog_cfg.enable ? hist[2 * analog_cfg.resp + 1] : ~cmp_result_in;
  end
endmodule
`default_nettype wire

// [verif/ced_comparator_props.sv]
// Concurrent checks on the comparator edge control ports
`timescale 1ns/10ps
`default_nettype none
// ====================
// Checker
module ced_comparator_props (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cmp_result_in,
  input wire logic       ctrl_wr_en,
  input wire logic [7:0] ctrl_wr_data,
  input wire logic [7:0] comparator_control_register,
  input wire logic [7:0] comparator_mode_register,
  input wire logic       raw_compare_output,
  input wire logic       latched_compare_output,
  input wire logic       irq_request,
  input wire logic       reset_source
);
  logic [7:0] cr;
  logic [7:0] mr;
  logic       lt;
  assign cr = comparator_control_register;
  assign mr = comparator_mode_register;
  assign lt = latched_compare_output;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Enable must be steady, the timing of a spurious flag at switch-on is left open
  sequence s_rise; cr[7] && $stable(cr[7]) && $rose(lt); endsequence
  sequence s_fall; cr[7] && $stable(cr[7]) && $fell(lt); endsequence
  property p_raw; raw_compare_output == (cmp_result_in && cr[7]); endproperty
  a_raw: assert property (p_raw) else $error("raw output wrong");
  property p_sync; cr[7] [*3] |-> lt == $past(cmp_result_in, 2); endproperty
  a_sync: assert property (p_sync) else $error("latched output wrong");
  property p_off; !cr[7] [*2] |-> !lt; endproperty
  a_off: assert property (p_off) else $error("latched output high while off");
  property p_rise; s_rise |=> cr[5]; endproperty
  a_rise: assert property (p_rise) else $error("rising flag missed");
  property p_fall; s_fall |=> cr[4]; endproperty
  a_fall: assert property (p_fall) else $error("falling flag missed");
  property p_keep; cr[5] && !(ctrl_wr_en && !ctrl_wr_data[5]) |=> cr[5]; endproperty
  a_keep: assert property (p_keep) else $error("rising flag lost");
  property p_clr; ctrl_wr_en && !ctrl_wr_data[4] && !$fell(lt) |=> !cr[4]; endproperty
  a_clr: assert property (p_clr) else $error("falling flag not cleared");
  property p_irq; irq_request == (cr[5] && mr[5] || cr[4] && mr[4]); endproperty
  a_irq: assert property (p_irq) else $error("interrupt wrong");
  property p_stat; cr[6] == lt && reset_source == lt; endproperty
  a_stat: assert property (p_stat) else $error("status wrong");
endmodule
bind ced_comparator ced_comparator_props i_props (.clock, .rst_n, .cmp_result_in, .ctrl_wr_en,
  .ctrl_wr_data, .comparator_control_register, .comparator_mode_register,
  .raw_compare_output, .latched_compare_output, .irq_request, .reset_source);
`default_nettype wire

// [verif/ced_comparator_tb.sv]
// Self-checking bench for the comparator edge control block
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench
module ced_comparator_tb;
  logic clock = 1'b0, rst_n = 1'b0, dpos = 1'b0, live = 1'b1, cw = 1'b0, sw = 1'b0, mw = 1'b0;
  logic [7:0] cd = 8'h00, sd = 8'h00, md = 8'h00, cr, sr, mr, ec, es, em;
  logic cmp, raw, lat, irq, rsrc, s1, s2, pv, rf, ff;
  ced_pkg::ced_analog_cfg_t cfg;
  int n_fail = 0, comparisons = 0, st = 0;
  ced_comparator i_dut (.clock(clock), .rst_n(rst_n), .cmp_result_in(cmp), .analog_cfg(cfg),
    .ctrl_wr_en(cw), .ctrl_wr_data(cd), .comparator_control_register(cr), .mux_wr_en(sw),
    .mux_wr_data(sd), .comparator_input_select_register(sr), .mode_wr_en(mw),
    .mode_wr_data(md), .comparator_mode_register(mr), .raw_compare_output(raw),
    .latched_compare_output(lat), .irq_request(irq), .reset_source(rsrc));
  ced_analog_model i_core (.clock(clock), .analog_cfg(cfg), .diff_pos(dpos), .cmp_result_in(cmp));
  always #5 clock = ~clock;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clock);
    #1 {cw, sw, mw} = 3'h4 >> k;
    {cd, sd, md} = {3{d}};
    @(posedge clock);
    #1 {cw, sw, mw} = 3'h0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycle model; set beats a same-cycle clear
  always @(posedge clock) begin
    if (!rst_n) begin
      {s1, s2, pv, rf, ff, st} <= '0;
      {ec, es, em} <= {8'h00, 8'hFF, 8'h02};
    end else begin
      s1 <= cmp;
      s2 <= ec[7] & s1;
      pv <= s2;
      rf <= (cw ? rf & cd[5] : rf) | (ec[7] & s2 & ~pv);
      ff <= (cw ? ff & cd[4] : ff) | (ec[7] & ~s2 & pv);
      if (cw) ec <= {cd[7], 3'h0, cd[3:0]};
      if (sw) es <= sd;
      if (mw) em <= md & 8'h33;
      st <= (cw && cd[7] != ec[7]) ? 0 : st + 1;
    end
  end
  always @(negedge clock) if (rst_n) begin
    chk(raw, cmp & ec[7]);
    chk(sr, es);
    chk(mr, em);
    chk(cfg.pos_pin_sel, es[3] ? 8'h00 : 8'h01 << es[2:0]);
    chk(cfg.neg_pin_sel, es[7] ? 8'h00 : 8'h01 << es[6:4]);
    chk({cfg.enable, cfg.pos_hyst, cfg.neg_hyst, cfg.resp}, {ec[7], ec[3:0], em[1:0]});
    if (live) chk(cr & 8'hBF, {ec[7], 1'b0, rf, ff, ec[3:0]});
    if (live) chk(irq, rf & em[5] | ff & em[4]);
    if (live && st > 3) chk({lat, cr[6], rsrc}, {3{s2}});
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h2C9BA1FD));
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr(1, {i[3:0], 4'hF - i[3:0]});
      wr(2, {6'($urandom), i[1:0]});
      wr(0, {4'h7, i[3:0]});
    end
    // Switch-on may leave false flags, so they are cleared once the core has settled
    live = 1'b0;
    wr(0, 8'h80);
    repeat (8) @(posedge clock);
    wr(0, 8'h80);
    live = 1'b1;
    repeat (400) begin
      @(posedge clock);
      #1 dpos = 1'($urandom);
      case ($urandom % 6)
        0: wr(2, 8'($urandom));
        1: wr(0, 8'($urandom) | 8'h80);
        default: ;
      endcase
    end
    wr(0, 8'h00);
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    print_verdict;
  end
endmodule
`default_nettype wire
